// ---- pkg/nps_pkg.sv ----
// Operation
// (RULE1) status read: command, three addresses, one data
// (RULE2) block number spread over three address bytes
// (RULE3) lowest block bit picks the plane
// (RULE4) byte reports lock state of addressed block
// (RULE5) bit 4 set when permanent range frozen
// (RULE6) bit 3 clear when block permanently protected
// (RULE7) bit 2 clear when block volatile locked
// (RULE8) bits 1:0 complementary volatile freeze pair
// (RULE9) ready/busy valid within 100 us
// (RULE10) reset is first command after power-up
// (RULE11) power-up reset loads internal configuration
// (RULE12) power-up reset busy at most 2 ms
// (RULE13) only read status allowed while reset busy
// (RULE14) shared enable needs enhanced read status
// (RULE15) after reset device sits in read setup
// (RULE16) hold write protect low during power-up
// (RULE17) ready/busy low during internal operations
// (RULE18) ready/busy only pulls low, wired-or
// (RULE19) reset while ready busy at most 5 us
// (RULE20) status byte taken with one read strobe
package nps_pkg;

  // ----------------------------------------
  // device commands
  // ----------------------------------------
  localparam logic [7:0] CMD_RESET      = 8'hff;
  localparam logic [7:0] CMD_PROT_READ  = 8'h7a;

  // ----------------------------------------
  // controller registers (byte addresses)
  // ----------------------------------------
  localparam logic [3:0] A_CTRL   = 4'h0;
  localparam logic [3:0] A_BLOCK  = 4'h4;
  localparam logic [3:0] A_STATUS = 4'h8;
  localparam logic [3:0] A_LOCK   = 4'hc;

  localparam int CTRL_GO   = 0;
  localparam int CTRL_RST  = 1;
  localparam int CTRL_WP   = 2;
  localparam int STAT_BUSY = 0;
  localparam int STAT_INIT = 1;
  localparam int STAT_TMO  = 2;
  localparam int STAT_RB   = 3;
  localparam int BLK_W     = 12;

  localparam logic [BLK_W-1:0] BLOCK_RST = 12'h000;
  localparam logic [7:0]       LOCK_RST  = 8'h00;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CNT_W         = 17;
  localparam int CLK_NS        = 25;
  localparam int T_RB_VALID_US = 100;
  localparam int T_PWR_RST_MS  = 2;
  localparam int T_RDY_RST_US  = 5;
  localparam int T_WB_NS       = 100;
  localparam int T_WHR_NS      = 60;
  localparam int T_RHW_NS      = 100;

  localparam int RB_VALID_CYC = (T_RB_VALID_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int PWR_RST_CYC_DEF = (T_PWR_RST_MS * 1000000 + CLK_NS - 1) / CLK_NS;
  localparam int RDY_RST_CYC  = (T_RDY_RST_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int WB_CYC       = (T_WB_NS + CLK_NS - 1) / CLK_NS + 2;
  localparam int WHR_CYC      = (T_WHR_NS + CLK_NS - 1) / CLK_NS;
  localparam int RHW_CYC      = (T_RHW_NS + CLK_NS - 1) / CLK_NS;
  localparam int RE_LOW_CYC   = 4;
  localparam int WR_PH_LAST   = 3;

  // ----------------------------------------
  // sequencer states
  // ----------------------------------------
  typedef enum logic [7:0] {
    S_PWR  = 8'h01,
    S_IDLE = 8'h02,
    S_CMD  = 8'h04,
    S_ADDR = 8'h08,
    S_TURN = 8'h10,
    S_READ = 8'h20,
    S_WB   = 8'h40,
    S_BUSY = 8'h80
  } nps_state_t;

endpackage

// ---- hw/nps_host.sv ----
`timescale 1ns/1ps
module nps_host import nps_pkg::*; #(
  parameter int unsigned PWR_RST_CYC = PWR_RST_CYC_DEF
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // register port
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  output logic      [31:0] rdata,
  // flash pins
  output logic             cle,
  output logic             ale,
  output logic             ce_b,
  output logic             we_b,
  output logic             re_b,
  output logic             wp_b,
  output logic      [7:0]  io_out,
  output logic             io_oe,
  input  wire logic [7:0]  io_in,
  input  wire logic        ready_busy_in
);

  typedef struct packed {
    nps_state_t       state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] lim;
    logic [1:0]       idx;
    logic             cmd_rd;
    logic             init_done;
    logic             timeout;
    logic             wp_rel;
    logic [BLK_W-1:0] blk;
    logic [7:0]       lock;
    logic [31:0]      rdata;
    logic             cle;
    logic             ale;
    logic             ce_b;
    logic             we_b;
    logic             re_b;
    logic             wp_b;
    logic [7:0]       io_out;
    logic             io_oe;
    logic             rb_s1;
    logic             rb_s2;
    logic [7:0]       io_s1;
    logic [7:0]       io_s2;
  } nps_regs_t;

  nps_regs_t r_r;
  nps_regs_t r_nxt;

  // ----------------------------------------
  // start of a command phase
  // ----------------------------------------
  function automatic nps_regs_t go_cmd(nps_regs_t s, logic [7:0] b, logic rd,
                                       logic [CNT_W-1:0] lim);
    nps_regs_t t;
    t         = s;
    t.state   = S_CMD;
    t.cnt     = '0;
    t.cle     = 1'b1;
    t.ce_b    = 1'b0;
    t.we_b    = 1'b1;
    t.io_out  = b;
    t.io_oe   = 1'b1;
    t.cmd_rd  = rd;
    t.lim     = lim;
    t.timeout = 1'b0;
    return t;
  endfunction

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    r_nxt       = r_r;
    r_nxt.rb_s1 = ready_busy_in;
    r_nxt.rb_s2 = r_r.rb_s1;
    r_nxt.io_s1 = io_in;
    r_nxt.io_s2 = r_r.io_s1;
    r_nxt.cnt   = r_r.cnt + CNT_W'(1);
    r_nxt.rdata = 32'h0;

    if (wr_stb) begin
      if (addr == A_CTRL) begin
        r_nxt.wp_rel = wdata[CTRL_WP];
      end else if (addr == A_BLOCK) begin
        r_nxt.blk = wdata[BLK_W-1:0];
      end
    end

    if (rd_stb) begin
      if (addr == A_CTRL) begin
        r_nxt.rdata[CTRL_WP] = r_r.wp_rel;
      end else if (addr == A_BLOCK) begin
        r_nxt.rdata[BLK_W-1:0] = r_r.blk;
      end else if (addr == A_STATUS) begin
        r_nxt.rdata[STAT_BUSY] = (r_r.state != S_IDLE);
        r_nxt.rdata[STAT_INIT] = r_r.init_done;
        r_nxt.rdata[STAT_TMO]  = r_r.timeout;
        r_nxt.rdata[STAT_RB]   = r_r.rb_s2;
      end else if (addr == A_LOCK) begin
        r_nxt.rdata[7:0] = r_r.lock;
      end
    end

    case (r_r.state)
      S_PWR: begin
        // wait until ready/busy is trustworthy, then reset first
        if (r_r.cnt == CNT_W'(RB_VALID_CYC - 1)) begin
          r_nxt = go_cmd(r_nxt, CMD_RESET, 1'b0, CNT_W'(PWR_RST_CYC)); // RULE10
        end
      end
      S_IDLE: begin
        if (wr_stb && addr == A_CTRL) begin
          if (wdata[CTRL_GO] && r_r.init_done) begin
            r_nxt = go_cmd(r_nxt, CMD_PROT_READ, 1'b1, '0); // RULE1
          end else if (wdata[CTRL_RST]) begin
            // a reset on a ready part is short; an unfinished init gets the long bound
            r_nxt = go_cmd(r_nxt, CMD_RESET, 1'b0,
                           r_r.init_done ? CNT_W'(RDY_RST_CYC) : CNT_W'(PWR_RST_CYC));
          end
        end
      end
      S_CMD: begin
        r_nxt.we_b = !(r_r.cnt == '0 || r_r.cnt == CNT_W'(1));
        if (r_r.cnt == CNT_W'(WR_PH_LAST)) begin
          r_nxt.cle = 1'b0;
          r_nxt.cnt = '0;
          if (r_r.cmd_rd) begin
            r_nxt.state  = S_ADDR;
            r_nxt.ale    = 1'b1;
            r_nxt.idx    = 2'd0;
            r_nxt.io_out = {r_r.blk[1:0], 6'h00}; // RULE2
          end else begin
            r_nxt.state = S_WB;
            r_nxt.io_oe = 1'b0;
          end
        end
      end
      S_ADDR: begin
        r_nxt.we_b = !(r_r.cnt == '0 || r_r.cnt == CNT_W'(1));
        if (r_r.cnt == CNT_W'(WR_PH_LAST)) begin
          r_nxt.cnt = '0;
          if (r_r.idx == 2'd2) begin
            r_nxt.state = S_TURN; // RULE1
            r_nxt.ale   = 1'b0;
            r_nxt.io_oe = 1'b0;
          end else begin
            r_nxt.idx = r_r.idx + 2'd1;
            if (r_r.idx == 2'd0) begin
              r_nxt.io_out = r_r.blk[9:2]; // RULE2
            end else begin
              r_nxt.io_out = {6'h00, r_r.blk[11:10]}; // RULE2
            end
          end
        end
      end
      S_TURN: begin
        if (r_r.cnt == CNT_W'(WHR_CYC - 1)) begin
          r_nxt.state = S_READ;
          r_nxt.cnt   = '0;
          r_nxt.re_b  = 1'b0;
        end
      end
      S_READ: begin
        // strobe held long enough for the pin data to clear the synchroniser
        if (r_r.cnt == CNT_W'(RE_LOW_CYC - 1)) begin
          r_nxt.re_b = 1'b1; // RULE20
          r_nxt.lock = r_r.io_s2; // RULE4
        end
        if (r_r.cnt == CNT_W'(RE_LOW_CYC + RHW_CYC - 1)) begin
          r_nxt.state = S_IDLE;
          r_nxt.ce_b  = 1'b1;
        end
      end
      S_WB: begin
        // device needs a moment before busy shows on the pin
        if (r_r.cnt == CNT_W'(WB_CYC - 1)) begin
          r_nxt.state = S_BUSY;
          r_nxt.cnt   = '0;
        end
      end
      S_BUSY: begin
        // single target: completion is watched on ready/busy alone, no commands sent
        if (r_r.rb_s2) begin // RULE13 RULE14
          r_nxt.state     = S_IDLE;
          r_nxt.ce_b      = 1'b1;
          r_nxt.init_done = 1'b1;
        end else if (r_r.cnt == r_r.lim) begin
          r_nxt.state   = S_IDLE;
          r_nxt.ce_b    = 1'b1;
          r_nxt.timeout = 1'b1;
        end
      end
      default: begin
        r_nxt.state = S_IDLE;
      end
    endcase

    r_nxt.wp_b = r_nxt.init_done & r_nxt.wp_rel; // RULE16
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r_r       <= '0;
      r_r.state <= S_PWR;
      r_r.ce_b  <= 1'b1;
      r_r.we_b  <= 1'b1;
      r_r.re_b  <= 1'b1;
      r_r.blk   <= BLOCK_RST;
      r_r.lock  <= LOCK_RST;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign rdata  = r_r.rdata;
  assign cle    = r_r.cle;
  assign ale    = r_r.ale;
  assign ce_b   = r_r.ce_b;
  assign we_b   = r_r.we_b;
  assign re_b   = r_r.re_b;
  assign wp_b   = r_r.wp_b;
  assign io_out = r_r.io_out;
  assign io_oe  = r_r.io_oe;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  chk_three_addr: assert property ( // RULE1
    r_r.state == S_ADDR && r_r.idx == 2'd2 && r_r.cnt == CNT_W'(WR_PH_LAST)
    |=> r_r.state == S_TURN ##WHR_CYC r_r.state == S_READ)
    else $error("status read did not turn to data after third address");

  chk_addr_low: assert property ( // RULE2
    r_r.state == S_ADDR && r_r.idx == 2'd0 && !r_r.we_b
    |-> r_r.io_out == {r_r.blk[1:0], 6'h00} && r_r.ale && !r_r.cle)
    else $error("first address byte misplaced");

  chk_addr_high: assert property ( // RULE2
    r_r.state == S_ADDR && r_r.idx == 2'd2 && !r_r.we_b
    |-> r_r.io_out == {6'h00, r_r.blk[11:10]})
    else $error("third address byte misplaced");

  chk_first_reset: assert property ( // RULE10
    r_r.state == S_PWR && r_nxt.state != S_PWR
    |=> r_r.state == S_CMD && r_r.io_out == CMD_RESET && r_r.cle)
    else $error("first command after power-up is not reset");

  chk_busy_quiet: assert property ( // RULE13
    r_r.state == S_BUSY |-> r_r.we_b && r_r.re_b && !r_r.io_oe)
    else $error("bus activity during reset busy");

  chk_rb_done: assert property ( // RULE14
    r_r.state == S_BUSY && r_r.rb_s2 |=> r_r.state == S_IDLE && r_r.init_done && r_r.ce_b)
    else $error("ready level did not end busy wait");

  chk_wp_powerup: assert property ( // RULE16
    !r_r.init_done |-> !r_r.wp_b)
    else $error("write protect released before init");

  chk_single_re: assert property ( // RULE20
    $fell(r_r.re_b) |-> !r_r.re_b [*4] ##1 (r_r.re_b && r_r.lock == $past(r_r.io_s2)))
    else $error("read strobe length or capture wrong");

endmodule

// ---- sim/nps_flash_model.sv ----
`timescale 1ns/1ps
// ------------------------------------------
// flash target model, single target on ce_b
// ------------------------------------------
module nps_flash_model (
  // clock for busy timing and the write-protect check
  input  wire logic       clk,
  // host pins
  input  wire logic       cle,
  input  wire logic       ale,
  input  wire logic       ce_b,
  input  wire logic       we_b,
  input  wire logic       re_b,
  input  wire logic       wp_b,
  input  wire logic [7:0] io_host,
  // lock state and a stuck-busy knob, both set by the bench
  input  wire logic       frz,
  input  wire logic       hold_busy,
  // device side
  output logic      [7:0] io_dev,
  output logic            io_dev_oe,
  output logic            rb_low,
  output int              viol
);
  logic [7:0]  cmd = 8'h00;
  logic [7:0]  ad [3];
  logic [11:0] blk = 12'h000;
  int          na = 0;
  int          nres = 0;
  int          nre = 0;
  int          cyc = 0;
  int          busy_end = 0;
  int          va = 0;
  int          vb = 0;
  int          vc = 0;
  logic [7:0]  dout = 8'h00;

  assign io_dev = dout;
  assign viol = va + vb + vc;
  // open-drain: only a pull-low enable, valid from time zero
  // hold_busy models a part that never finishes, to reach the host's timeout
  assign rb_low = hold_busy || cyc < busy_end;
  assign io_dev_oe = !ce_b && !re_b && cmd == 8'h7a && na == 3;

  always @(posedge clk) begin
    cyc++;
    // write protect must stay low until the first reset is over
    if (wp_b && (nres == 0 || (nres == 1 && rb_low))) vb++;
  end

  always @(posedge we_b) begin
    if (!ce_b && cle && (!rb_low || io_host == 8'h70)) begin
      if (nres == 0 && io_host != 8'hff) va++;
      na = 0;
      nre = 0;
      cmd = (io_host == 8'hff) ? 8'h00 : io_host;
      if (io_host == 8'hff) begin
        // first reset loads configuration, so it runs longer
        busy_end = cyc + ((nres == 0) ? 150 : 40);
        nres++;
      end
    end else if (!ce_b && ale && na < 3) begin
      ad[na] = io_host;
      na++;
      if (na == 3 && (ad[0][5:0] != 6'h00 || ad[2][7:2] != 6'h00)) va++;
      if (na == 3) blk = {ad[2][1:0], ad[1], ad[0][7:6]};
    end
  end

  always @(negedge re_b) begin
    if (!ce_b && cmd == 8'h7a && na == 3) begin
      dout = {3'h0, frz, blk >= 12'h040, ~(blk[11] ^ blk[0]), ~frz, frz};
      nre++;
      if (nre > 1) vc++;
    end
  end
endmodule

// ---- sim/test_nps_host.sv ----
`timescale 1ns/1ps
module test_nps_host import nps_pkg::*;;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic        wr_stb = 1'b0;
  logic        rd_stb = 1'b0;
  logic        frz = 1'b0;
  logic        hold_busy = 1'b0;
  logic [31:0] rdata;
  logic        cle, ale, ce_b, we_b, re_b, wp_b, io_oe, io_dev_oe, rb_low;
  logic [7:0]  io_out, io_dev, io_in, io_bus;
  logic        ready_busy_in;
  logic [31:0] d;
  int          viol;
  int          err_count = 0;
  int          tests_run = 0;
  int          cyc = 0;

  // pull-up on the wired ready/busy line; a released bus shows inverted data
  assign ready_busy_in = ~rb_low;
  assign io_in = io_dev_oe ? io_dev : ~io_dev;
  assign io_bus = io_oe ? io_out : io_in;

  nps_host #(.PWR_RST_CYC(300)) nps_host_inst (.clk(clk), .rst_b(rst_b), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .cle(cle), .ale(ale),
    .ce_b(ce_b), .we_b(we_b), .re_b(re_b), .wp_b(wp_b), .io_out(io_out), .io_oe(io_oe),
    .io_in(io_in), .ready_busy_in(ready_busy_in));
  nps_flash_model nps_flash_model_inst (.clk(clk), .cle(cle), .ale(ale), .ce_b(ce_b),
    .we_b(we_b), .re_b(re_b), .wp_b(wp_b), .io_host(io_bus), .frz(frz), .io_dev(io_dev),
    .io_dev_oe(io_dev_oe), .rb_low(rb_low), .viol(viol), .hold_busy(hold_busy));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic complete_run();
    $display("checks %0d errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 v = rdata;
  endtask

  // poll status until idle with init done and R/B high; notes any busy seen
  task automatic wait_done(input int n, output logic sn);
    logic [31:0] s;
    sn = 1'b0;
    rd(A_STATUS, s);
    while ((s & 32'hf) !== 32'ha && n > 0) begin
      if (s[STAT_RB] === 1'b0) sn = 1'b1;
      rd(A_STATUS, s);
      n--;
    end
    chk(s & 32'hf, 32'ha, "status idle");
  endtask

  function automatic logic [7:0] exp_stat(input logic [11:0] b, input logic f);
    return {3'h0, f, b >= 12'h040, ~(b[11] ^ b[0]), ~f, f};
  endfunction

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_prot(input logic [11:0] b);
    logic [31:0] v;
    logic        sn;
    wr(A_BLOCK, {20'h0, b});
    rd(A_BLOCK, v);
    chk(v, {20'h0, b}, "block readback");
    wr(A_CTRL, 32'h5);
    wr(A_CTRL, 32'h5);
    wait_done(60, sn);
    rd(A_LOCK, v);
    chk(v, {24'h0, exp_stat(b, frz)}, "lock byte");
  endtask

  task automatic t_after_reset();
    chk({25'h0, ce_b, we_b, re_b, wp_b, cle, ale, io_oe}, 32'h70, "idle pins");
    rd(A_LOCK, d);
    chk(d, 32'h0, "lock reset");
    rd(4'h2, d);
    chk(d, 32'h0, "unmapped");
    rd(A_STATUS, d);
    chk({31'h0, d[STAT_INIT]}, 32'h0, "init clear");
  endtask

  task automatic t_power_up();
    logic sn;
    wait_done(3000, sn);
    chk({31'h0, sn}, 32'h1, "power-up busy seen");
  endtask

  task automatic t_wp_release();
    wr(A_CTRL, 32'h4);
    repeat (3) @(posedge clk);
    chk({31'h0, wp_b}, 32'h1, "wp released");
  endtask

  task automatic t_ready_reset();
    logic sn;
    wr(A_CTRL, 32'h6);
    wait_done(200, sn);
    chk({31'h0, sn}, 32'h1, "ready reset busy seen");
  endtask

  // a part stuck busy must end in a timeout; the next reset clears the flag
  task automatic t_stuck_busy();
    logic [31:0] s;
    logic        sn;
    hold_busy <= 1'b1;
    wr(A_CTRL, 32'h6);
    repeat (RDY_RST_CYC + 40) @(posedge clk);
    rd(A_STATUS, s);
    chk(s & 32'hf, 32'h6, "reset busy timeout");
    hold_busy <= 1'b0;
    wr(A_CTRL, 32'h6);
    wait_done(200, sn);
    chk({31'h0, sn}, 32'h1, "busy seen after timeout");
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      complete_run();
    end
  end

  initial forever #12.5 clk = ~clk;

  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    t_after_reset();
    t_power_up();
    t_wp_release();
    for (int i = 0; i < 6; i++) t_prot(i[0] ? 12'h801 : 12'hfff - 12'(i * 12'h3e0));
    t_prot(12'h000);
    t_prot(12'h03f);
    frz <= 1'b1;
    t_prot(12'h040);
    t_ready_reset();
    t_prot(12'h401);
    t_stuck_busy();
    chk(viol, 0, "host pin protocol");
    complete_run();
  end
endmodule
